// *** core/cafdp_regs.vh ***
// Register offsets, field positions, reset values and operation codes
`ifndef CAFDP_REGS_VH
`define CAFDP_REGS_VH

// Register offsets on the special-register port
`define CAFDP_PTR_CTRL_ADDR 8'ha7
`define CAFDP_PTR_LO_ADDR 8'hb2
`define CAFDP_PTR_HI_ADDR 8'hb3

// Pointer control fields
`define CAFDP_SEL_BIT 0
`define CAFDP_SWAP_BIT 6
`define CAFDP_SHD_MODE_HI 5
`define CAFDP_SHD_MODE_LO 4
`define CAFDP_MAIN_MODE_HI 3
`define CAFDP_MAIN_MODE_LO 2
`define CAFDP_CTRL_WMASK 8'h7d
`define CAFDP_CTRL_RESET 8'h00

// Pointer mode encodings
`define CAFDP_MODE_PLAIN 2'h0
`define CAFDP_MODE_INC 2'h1
`define CAFDP_MODE_DEC 2'h2
`define CAFDP_MODE_TOGGLE 2'h3

// Operation codes of the arithmetic request port
`define CAFDP_OP_MUL 3'h0
`define CAFDP_OP_DIV 3'h1
`define CAFDP_OP_DADJ 3'h2
`define CAFDP_OP_ROR 3'h3
`define CAFDP_OP_ROL 3'h4
`define CAFDP_OP_CMPJ 3'h5

// Arithmetic constants
`define CAFDP_BYTE_MAX 16'h00ff
`define CAFDP_NIBBLE_MAX 4'h9
`define CAFDP_LOW_FIX 9'h006
`define CAFDP_HIGH_FIX 9'h060
`define CAFDP_BCD_MAX 9'h099

`endif

// *** core/cafdp_core.v ***
// ALU flag operations and dual data pointer unit of the core datapath
//
// How it works
// RULE_01 - Multiply: low byte to A, high to B
// RULE_02 - Multiply clears carry, overflow above 255
// RULE_03 - Divide: quotient to A, remainder to B
// RULE_04 - Divide clears flags; zero divisor sets overflow
// RULE_05 - Adjust adds 06 on aux carry/nibble>9
// RULE_06 - Adjust adds 60 on carry or low fix
// RULE_07 - Adjust sets carry when result exceeds 99
// RULE_08 - Rotate right: bit0 to carry, carry in
// RULE_09 - Rotate left: bit7 to carry, carry in
// RULE_10 - Compare-jump branches when values differ
// RULE_11 - Compare-jump carry when source exceeds destination
// RULE_12 - Two pointers, selected through control register
// RULE_13 - Auto update only for pointer-addressed moves
// RULE_14 - Bit 6 swaps active pointer after moves
// RULE_15 - Bit 7 unimplemented, reads zero
// RULE_16 - Bits 5:4 hold shadow pointer mode
// RULE_17 - Modes: plain, increment, decrement, toggle bit0
// RULE_18 - Bits 3:2 hold main pointer mode
// RULE_19 - Mode update first, swap for next move
`timescale 1ns/100ps
`include "cafdp_regs.vh"

module cafdp_core #(
    parameter PTR_W = 16
) (
    CLOCK,
    RESET_N,
    OP_VALID,
    OP_CODE,
    ACC_IN,
    B_IN,
    CY_IN,
    AUX_IN,
    CMP_SRC,
    CMP_DST,
    OP_DONE,
    ACC_OUT,
    B_OUT,
    CY_OUT,
    OV_OUT,
    OV_WE,
    BRANCH_TAKEN,
    MOVE_VALID,
    MOVE_VIA_PTR,
    PTR_LOAD,
    PTR_LOAD_DATA,
    ACTIVE_PTR,
    SHADOW_ACTIVE,
    REG_ADDR,
    REG_WDATA,
    REG_WR,
    REG_RD,
    REG_RDATA
);
    // Clock and asynchronous reset
    input wire CLOCK;
    input wire RESET_N;
    // Arithmetic request, operands sampled with it
    input wire OP_VALID;
    input wire [2:0] OP_CODE;
    input wire [7:0] ACC_IN;
    input wire [7:0] B_IN;
    input wire CY_IN;
    input wire AUX_IN;
    input wire [7:0] CMP_SRC;
    input wire [7:0] CMP_DST;
    // Arithmetic results, all registered
    output reg OP_DONE;
    output reg [7:0] ACC_OUT;
    output reg [7:0] B_OUT;
    output reg CY_OUT;
    output reg OV_OUT;
    output reg OV_WE;
    output reg BRANCH_TAKEN;
    // Move completion and direct pointer load
    input wire MOVE_VALID;
    input wire MOVE_VIA_PTR;
    input wire PTR_LOAD;
    input wire [PTR_W-1:0] PTR_LOAD_DATA;
    output reg [PTR_W-1:0] ACTIVE_PTR;
    output reg SHADOW_ACTIVE;
    // Special-register port; read data one cycle late
    input wire [7:0] REG_ADDR;
    input wire [7:0] REG_WDATA;
    input wire REG_WR;
    input wire REG_RD;
    output reg [7:0] REG_RDATA;

    // Pointer storage, index 0 main, index 1 shadow
    reg [PTR_W-1:0] ptr_q [0:1];
    reg [PTR_W-1:0] ptr_d [0:1];
    // Control register, bit 7 and bit 1 never stored
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;

    // Datapath results, computed combinationally
    reg [7:0] acc_d;
    reg [7:0] b_d;
    reg cy_d;
    reg ov_d;
    reg ov_we_d;
    reg br_d;
    // Intermediate values of multiply and decimal adjust
    reg [15:0] prod;
    reg [8:0] da_sum;
    reg low_fix;

    // Pointer update helpers
    wire sel = ctrl_q[`CAFDP_SEL_BIT];
    // Main pointer mode field
    wire [1:0] main_mode =
        ctrl_q[`CAFDP_MAIN_MODE_HI:`CAFDP_MAIN_MODE_LO]; // see RULE_18
    // Shadow pointer mode field
    wire [1:0] shd_mode =
        ctrl_q[`CAFDP_SHD_MODE_HI:`CAFDP_SHD_MODE_LO]; // see RULE_16
    wire [1:0] act_mode = sel ? shd_mode : main_mode;
    wire [PTR_W-1:0] act_ptr = ptr_q[sel];
    // Unit step at pointer width, so no operand is widened silently
    wire [PTR_W-1:0] ptr_one = {{(PTR_W-1){1'b0}}, 1'b1};
    // Active pointer after its mode step
    reg [PTR_W-1:0] upd_ptr;
    // Register port decode
    wire hit_ctrl = (REG_ADDR == `CAFDP_PTR_CTRL_ADDR);
    wire hit_lo = (REG_ADDR == `CAFDP_PTR_LO_ADDR);
    wire hit_hi = (REG_ADDR == `CAFDP_PTR_HI_ADDR);

    // Arithmetic operations; A, B, carry and overflow hold when no request
    always @* begin
        acc_d = ACC_OUT;
        b_d = B_OUT;
        cy_d = CY_OUT;
        ov_d = OV_OUT;
        ov_we_d = 1'b0;
        br_d = 1'b0;
        // Operands widened first so the full product is kept
        prod = {8'h00, ACC_IN} * {8'h00, B_IN};
        low_fix = AUX_IN | (ACC_IN[3:0] > `CAFDP_NIBBLE_MAX); // see RULE_05
        da_sum = {1'b0, ACC_IN};
        if (low_fix) begin
            da_sum = da_sum + `CAFDP_LOW_FIX; // see RULE_05
        end
        // Carry as it stood at the start, not any carry of step one
        if (CY_IN | low_fix) begin
            da_sum = da_sum + `CAFDP_HIGH_FIX; // see RULE_06
        end
        // Only a request changes A, B, carry and overflow; idle cycles hold them and clear OV_WE and BRANCH_TAKEN
        if (OP_VALID) begin
            case (OP_CODE)
                // Low product byte to A, high byte to B
                `CAFDP_OP_MUL: begin
                    acc_d = prod[7:0]; // see RULE_01
                    b_d = prod[15:8];
                    cy_d = 1'b0; // see RULE_02
                    ov_d = (prod > `CAFDP_BYTE_MAX); // see RULE_02
                    ov_we_d = 1'b1;
                end
                // Zero divisor raises overflow instead of dividing
                `CAFDP_OP_DIV: begin
                    cy_d = 1'b0; // see RULE_04
                    ov_we_d = 1'b1;
                    if (B_IN == 8'h00) begin
                        // Results undefined; keep operands unchanged
                        acc_d = ACC_IN;
                        b_d = B_IN;
                        ov_d = 1'b1; // see RULE_04
                    end else begin
                        // Quotient and remainder of one unsigned divide
                        acc_d = ACC_IN / B_IN; // see RULE_03
                        b_d = ACC_IN % B_IN; // see RULE_03
                        ov_d = 1'b0; // see RULE_04
                    end
                end
                // Both corrections are already folded into da_sum
                `CAFDP_OP_DADJ: begin
                    acc_d = da_sum[7:0];
                    b_d = B_IN;
                    cy_d = (da_sum > `CAFDP_BCD_MAX); // see RULE_07
                end
                // Carry enters at the top, bit 0 leaves into carry
                `CAFDP_OP_ROR: begin
                    acc_d = {CY_IN, ACC_IN[7:1]}; // see RULE_08
                    b_d = B_IN;
                    cy_d = ACC_IN[0]; // see RULE_08
                end
                // Carry enters at the bottom, bit 7 leaves into carry
                `CAFDP_OP_ROL: begin
                    acc_d = {ACC_IN[6:0], CY_IN}; // see RULE_09
                    b_d = B_IN;
                    cy_d = ACC_IN[7]; // see RULE_09
                end
                // Operands pass through; only carry and branch change
                `CAFDP_OP_CMPJ: begin
                    acc_d = ACC_IN;
                    b_d = B_IN;
                    br_d = (CMP_SRC != CMP_DST); // see RULE_10
                    cy_d = (CMP_SRC > CMP_DST); // see RULE_11
                end
                default: begin
                    // Unused codes pass the A, B and carry inputs straight through
                    acc_d = ACC_IN;
                    b_d = B_IN;
                    cy_d = CY_IN;
                end
            endcase
        end
    end

    // Post-move value of the active pointer per its mode
    always @* begin
        case (act_mode) // see RULE_17
            // Increment and decrement wrap round at the pointer width
            `CAFDP_MODE_INC: upd_ptr = act_ptr + ptr_one;
            `CAFDP_MODE_DEC: upd_ptr = act_ptr - ptr_one;
            // Toggle flips only bit 0, for byte pairs of wide devices
            `CAFDP_MODE_TOGGLE: upd_ptr = act_ptr ^ ptr_one;
            // Plain mode leaves the pointer where it was
            default: upd_ptr = act_ptr;
        endcase
    end

    // Next pointer and control state
    always @* begin
        // Defaults: pointers and control hold
        ptr_d[0] = ptr_q[0];
        ptr_d[1] = ptr_q[1];
        ctrl_d = ctrl_q;
        // Mode update lands on the pointer used by this move
        if (MOVE_VALID && MOVE_VIA_PTR) begin
            ptr_d[sel] = upd_ptr; // see RULE_13
        end
        // Swap after the update, so it serves the next move
        if (MOVE_VALID && ctrl_q[`CAFDP_SWAP_BIT]) begin
            ctrl_d[`CAFDP_SEL_BIT] = ~sel; // see RULE_14, RULE_19
        end
        // Explicit loads override a same-cycle auto update
        if (PTR_LOAD) begin
            ptr_d[sel] = PTR_LOAD_DATA; // see RULE_12
        end
        // Software writes win over every automatic change
        if (REG_WR) begin
            if (hit_ctrl) begin
                // Bits 7 and 1 are masked off on write
                ctrl_d = REG_WDATA & `CAFDP_CTRL_WMASK; // see RULE_15
            end else if (hit_lo) begin
                ptr_d[sel][7:0] = REG_WDATA; // see RULE_12
            end else if (hit_hi) begin
                // High byte covers the upper pointer bits
                ptr_d[sel][PTR_W-1:8] = REG_WDATA[PTR_W-9:0];
            end
        end
    end

    // State registers and registered outputs
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ptr_q[0] <= {PTR_W{1'b0}};
            ptr_q[1] <= {PTR_W{1'b0}};
            // Main pointer active, both modes plain, no swap
            ctrl_q <= `CAFDP_CTRL_RESET; // see RULE_14, RULE_16, RULE_18
            // Results read as zero until the first request
            OP_DONE <= 1'b0;
            ACC_OUT <= 8'h00;
            B_OUT <= 8'h00;
            CY_OUT <= 1'b0;
            OV_OUT <= 1'b0;
            OV_WE <= 1'b0;
            BRANCH_TAKEN <= 1'b0;
            ACTIVE_PTR <= {PTR_W{1'b0}};
            SHADOW_ACTIVE <= 1'b0;
            REG_RDATA <= 8'h00;
        end else begin
            ptr_q[0] <= ptr_d[0];
            ptr_q[1] <= ptr_d[1];
            ctrl_q <= ctrl_d;
            // Done follows each request by exactly one cycle
            OP_DONE <= OP_VALID;
            ACC_OUT <= acc_d;
            B_OUT <= b_d;
            CY_OUT <= cy_d;
            OV_OUT <= ov_d;
            OV_WE <= ov_we_d;
            BRANCH_TAKEN <= br_d;
            // Outputs follow the state that the next cycle sees
            ACTIVE_PTR <= ptr_d[ctrl_d[`CAFDP_SEL_BIT]]; // see RULE_12
            SHADOW_ACTIVE <= ctrl_d[`CAFDP_SEL_BIT];
            // Read data shows pre-write state; unmapped reads give zero
            if (REG_RD) begin
                if (hit_ctrl) begin
                    REG_RDATA <= ctrl_q; // see RULE_15, RULE_16, RULE_18
                end else if (hit_lo) begin
                    REG_RDATA <= act_ptr[7:0];
                end else if (hit_hi) begin
                    REG_RDATA <= act_ptr[PTR_W-1:8];
                end else begin
                    REG_RDATA <= 8'h00;
                end
            end else begin
                REG_RDATA <= 8'h00;
            end
        end
    end

endmodule

// *** verif/cafdp_monitor.sv ***
// Port-level checks of the ALU flags and data pointer core
`timescale 1ns/100ps
module cafdp_monitor #(
    parameter PTR_W = 16
) (
    input logic CLOCK,
    input logic RESET_N,
    input logic OP_VALID,
    input logic [2:0] OP_CODE,
    input logic [7:0] ACC_IN,
    input logic [7:0] B_IN,
    input logic CY_IN,
    input logic [7:0] CMP_SRC,
    input logic [7:0] CMP_DST,
    input logic [7:0] ACC_OUT,
    input logic [7:0] B_OUT,
    input logic CY_OUT,
    input logic OV_OUT,
    input logic BRANCH_TAKEN,
    input logic MOVE_VALID,
    input logic PTR_LOAD,
    input logic REG_WR,
    input logic [PTR_W-1:0] PTR_LOAD_DATA,
    input logic [PTR_W-1:0] ACTIVE_PTR,
    input logic SHADOW_ACTIVE
);
    // One clock domain, checks idle while in reset
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // Request decodes
    wire op_mul = OP_VALID && OP_CODE == 3'h0;
    wire op_div = OP_VALID && OP_CODE == 3'h1;
    wire op_rr = OP_VALID && OP_CODE == 3'h3;
    wire op_rl = OP_VALID && OP_CODE == 3'h4;
    wire op_cj = OP_VALID && OP_CODE == 3'h5;
    mul_product_a: assert property (op_mul |=>
        {B_OUT, ACC_OUT} == $past(ACC_IN) * $past(B_IN))
        else $error("product");
    mul_flags_a: assert property (op_mul |=>
        !CY_OUT && OV_OUT == (B_OUT != 8'h00)) else $error("mul flags");
    div_result_a: assert property (op_div && B_IN != 8'h00 |=>
        ACC_OUT == $past(ACC_IN) / $past(B_IN) &&
        B_OUT == $past(ACC_IN) % $past(B_IN)) else $error("quotient");
    div_flags_a: assert property (op_div |=>
        !CY_OUT && OV_OUT == ($past(B_IN) == 8'h00)) else $error("div flags");
    rot_right_a: assert property (op_rr |=>
        {ACC_OUT, CY_OUT} == {$past(CY_IN), $past(ACC_IN)})
        else $error("rotate right");
    rot_left_a: assert property (op_rl |=>
        {CY_OUT, ACC_OUT} == {$past(ACC_IN), $past(CY_IN)})
        else $error("rotate left");
    cmp_jump_a: assert property (op_cj |=>
        BRANCH_TAKEN == ($past(CMP_SRC) != $past(CMP_DST)) &&
        CY_OUT == ($past(CMP_SRC) > $past(CMP_DST)))
        else $error("compare jump");
    ptr_load_a: assert property (
        PTR_LOAD && !REG_WR && !MOVE_VALID |=>
        ACTIVE_PTR == $past(PTR_LOAD_DATA)) else $error("pointer load");
    ptr_hold_a: assert property (
        !MOVE_VALID && !PTR_LOAD && !REG_WR |=>
        $stable(ACTIVE_PTR) && $stable(SHADOW_ACTIVE))
        else $error("ptr moved");
endmodule
bind cafdp_core cafdp_monitor #(.PTR_W(PTR_W)) cafdp_monitor_i (.CLOCK,
    .RESET_N, .OP_VALID, .OP_CODE, .ACC_IN, .B_IN, .CY_IN, .CMP_SRC,
    .CMP_DST, .ACC_OUT, .B_OUT, .CY_OUT, .OV_OUT, .BRANCH_TAKEN, .MOVE_VALID,
    .PTR_LOAD, .REG_WR, .PTR_LOAD_DATA, .ACTIVE_PTR, .SHADOW_ACTIVE);

// *** verif/cafdp_tb.sv ***
// Self-checking bench for the ALU flags and dual pointer core
`timescale 1ns/100ps
module tb;
    logic clk = 0, rst_n = 0, op_v = 0, cy = 0, aux = 0, mv = 0, via = 0;
    logic ld = 0, wr = 0, rd = 0, done, cy_o, ov, ov_we, br, sh;
    logic [2:0] op = 0;
    logic [7:0] a = 0, b = 0, src = 0, dst = 0, adr = 0, wd = 0, ao, bo, rdat;
    logic [15:0] ld_d = 0, ptr;
    logic [15:0] mt [4] = '{16'h2010, 16'h0f11, 16'hffff, 16'h1010};
    logic [15:0] dt [3] = '{16'hfb12, 16'h0701, 16'h0509};
    logic [15:0] ct [3] = '{16'h0503, 16'h0305, 16'h0707};
    // Accumulator, carry and aux carry packed as {a, cy, aux}
    logic [9:0] dat [7] = '{10'h0f0, 10'h048, 10'h04a, 10'h065, 10'h282,
        10'h264, 10'h268};
    logic [8:0] rt [2] = '{9'h102, 9'h005};
    int num_errors = 0, check_count = 0, cyc = 0;
    always #5 clk = ~clk;
    cafdp_core cafdp_core_i (.CLOCK(clk), .RESET_N(rst_n), .OP_VALID(op_v),
        .OP_CODE(op), .ACC_IN(a), .B_IN(b), .CY_IN(cy), .AUX_IN(aux),
        .CMP_SRC(src), .CMP_DST(dst), .OP_DONE(done), .ACC_OUT(ao), .B_OUT(bo),
        .CY_OUT(cy_o), .OV_OUT(ov), .OV_WE(ov_we), .BRANCH_TAKEN(br),
        .MOVE_VALID(mv), .MOVE_VIA_PTR(via), .PTR_LOAD(ld),
        .PTR_LOAD_DATA(ld_d), .ACTIVE_PTR(ptr), .SHADOW_ACTIVE(sh),
        .REG_ADDR(adr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdat));
    task test_done;
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // Strobes last one cycle; results are sampled once the edge has landed
    task alu(input logic [2:0] c, input logic [7:0] x, y, input logic ci, ai);
        @(posedge clk);
        {op_v, op, a, b, cy, aux} <= {1'b1, c, x, y, ci, ai};
        @(posedge clk);
        op_v <= 0;
        #1;
    endtask
    task wreg(input logic [7:0] ad, d);
        @(posedge clk);
        {wr, adr, wd} <= {1'b1, ad, d};
        @(posedge clk);
        wr <= 0;
    endtask
    task rreg(input logic [7:0] ad, e);
        @(posedge clk);
        {rd, adr} <= {1'b1, ad};
        @(posedge clk);
        rd <= 0;
        #1;
        chk("reg_rdata", e, rdat);
    endtask
    task load(input logic [15:0] d);
        @(posedge clk);
        {ld, ld_d} <= {1'b1, d};
        @(posedge clk);
        ld <= 0;
        #1;
    endtask
    task move(input logic p, input logic [15:0] e, input logic s);
        @(posedge clk);
        {mv, via} <= {1'b1, p};
        @(posedge clk);
        mv <= 0;
        #1;
        chk("active_ptr", e, ptr);
        chk("shadow_active", s, sh);
    endtask
    // Decimal adjust worked out step by step
    function automatic logic [8:0] dadj(input logic [7:0] x,
        input logic c, hc);
        logic [8:0] t;
        logic lo;
        t = {1'b0, x};
        lo = hc || x[3:0] > 4'h9;
        if (lo)
            t = t + 9'h006;
        if (c || lo)
            t = t + 9'h060;
        return t;
    endfunction
    // Hang guard, far above the length of the sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            test_done;
        end
    end
    initial begin
        logic [8:0] t;
        repeat (6) @(posedge clk);
        rst_n <= 1;
        rreg(8'ha7, 8'h00);
        foreach (mt[i]) begin
            alu(3'h0, mt[i][15:8], mt[i][7:0], 1, 0);
            chk("product", mt[i][15:8] * mt[i][7:0], {bo, ao});
            chk("op_done", 1'b1, done);
            t = {1'b0, mt[i][15:8] * mt[i][7:0] > 255, 1'b1};
            chk("mul_flags", t, {cy_o, ov, ov_we});
        end
        foreach (dt[i]) begin
            alu(3'h1, dt[i][15:8], dt[i][7:0], 1, 0);
            chk("quotient", dt[i][15:8] / dt[i][7:0], ao);
            chk("remainder", dt[i][15:8] % dt[i][7:0], bo);
            chk("div_flags", 3'b001, {cy_o, ov, ov_we});
        end
        alu(3'h1, 8'h42, 8'h00, 1, 0);
        chk("div_zero", 3'b011, {cy_o, ov, ov_we});
        foreach (dat[i]) begin
            t = dadj(dat[i][9:2], dat[i][1], dat[i][0]);
            alu(3'h2, dat[i][9:2], 8'h00, dat[i][1], dat[i][0]);
            chk("adjusted", t[7:0], ao);
            chk("adjust_carry", t > 9'h099, cy_o);
        end
        foreach (rt[i]) begin
            alu(3'h3, rt[i][8:1], 8'h00, rt[i][0], 0);
            chk("rot_r", {rt[i][0], rt[i][8:1]}, {ao, cy_o});
            alu(3'h4, rt[i][8:1], 8'h00, rt[i][0], 0);
            chk("rot_left", {rt[i][8:1], rt[i][0]}, {cy_o, ao});
        end
        foreach (ct[i]) begin
            @(posedge clk);
            {src, dst} <= ct[i];
            alu(3'h5, 8'h00, 8'h00, 0, 0);
            chk("branch", ct[i][15:8] != ct[i][7:0], br);
            chk("cmp_carry", ct[i][15:8] > ct[i][7:0], cy_o);
        end
        wreg(8'ha7, 8'hff);
        rreg(8'ha7, 8'h7d);
        rreg(8'h10, 8'h00);
        wreg(8'ha7, 8'h00);
        load(16'h0000);
        wreg(8'ha7, 8'h55);
        rreg(8'ha7, 8'h55);
        load(16'hd000);
        chk("active_ptr", 16'hd000, ptr);
        move(1, 16'h0000, 0);
        move(1, 16'hd001, 1);
        move(0, 16'h0001, 0);
        wreg(8'ha7, 8'h28);
        move(1, 16'h0000, 0);
        move(1, 16'hffff, 0);
        wreg(8'ha7, 8'h0c);
        move(1, 16'hfffe, 0);
        wreg(8'ha7, 8'h00);
        move(1, 16'hfffe, 0);
        wreg(8'ha7, 8'h31);
        move(1, 16'hd000, 1);
        rreg(8'hb3, 8'hd0);
        wreg(8'hb2, 8'h34);
        rreg(8'hb2, 8'h34);
        chk("active_ptr", 16'hd034, ptr);
        test_done;
    end
endmodule
